// *** include/dsasp_pkg.sv ***
`default_nettype none
package dsasp_pkg;
	localparam int unsigned NUM_SUB        = 2;
	localparam int unsigned FIFO_DEPTH_DEF = 8;
	localparam int unsigned WORD_W         = 32;
	localparam int unsigned ERR_W          = 4;
	localparam int unsigned ERR_OVUD       = 0;
	localparam int unsigned ERR_EARLY      = 1;
	localparam int unsigned ERR_LATE       = 2;
	localparam int unsigned ERR_NRDY       = 3;
	localparam logic [2:0]  DSIZE_8        = 3'h0;
	localparam logic [2:0]  DSIZE_10       = 3'h1;
	localparam logic [2:0]  DSIZE_16       = 3'h2;
	localparam logic [2:0]  DSIZE_20       = 3'h3;
	localparam logic [2:0]  DSIZE_24       = 3'h4;
	localparam logic [2:0]  DSIZE_32       = 3'h5;
	localparam logic [5:0]  WS_8           = 6'h08;
	localparam logic [5:0]  WS_10          = 6'h0a;
	localparam logic [5:0]  WS_16          = 6'h10;
	localparam logic [5:0]  WS_20          = 6'h14;
	localparam logic [5:0]  WS_24          = 6'h18;
	localparam logic [5:0]  WS_32          = 6'h20;
	localparam logic [4:0]  SLOT_IDLE      = 5'h1f;
	localparam logic [4:0]  SLOT_MONO_REP  = 5'h01;

	typedef struct packed {
		logic        en;          // Sub-block enable.
		logic        tx;          // 1 transmitter, 0 receiver.
		logic        master;      // Drive bit clock and frame sync.
		logic        sync;        // Sub-block 1 follows sub-block 0 timing.
		logic [2:0]  dsize;       // Data size code.
		logic [5:0]  slot_sz_m1;  // Bit clocks per slot minus one.
		logic [3:0]  nslot_m1;    // Slots per frame minus one.
		logic [15:0] slot_en;     // Active slot mask.
		logic [8:0]  frame_m1;    // Bit clocks per frame minus one.
		logic [7:0]  fs_len;      // Frame sync length in bit clocks.
		logic        fs_pol;      // 1 frame sync active high.
		logic        fs_early;    // Frame sync one bit before data.
		logic [4:0]  first_bit;   // First data bit position in slot.
		logic        lsb_first;   // Bit order on the line.
		logic        mono;        // Slot 1 repeats slot 0.
		logic        mute;        // Transmit silence.
		logic        smp_rise;    // Sample on rising edge, launch falling.
		logic        ac97;        // Codec ready check in reception.
		logic [7:0]  clk_div;     // Half bit clock in link clocks minus one.
	} dsasp_cfg_s;

	typedef struct packed {
		logic [3:0] err;  // Per-flag enable.
		logic       req;  // FIFO request enable.
	} dsasp_irqen_s;

	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic fs;
		logic fs_oe;
		logic sd;
		logic sd_oe;
	} dsasp_pin_s;

	typedef struct packed {
		logic       act;
		logic       first;
		logic       last;
		logic       rep;
		logic [4:0] idx;
	} dsasp_bit_s;
endpackage
`default_nettype wire

// *** rtl/dsasp_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsasp_top #(
	parameter int unsigned FIFO_DEPTH = dsasp_pkg::FIFO_DEPTH_DEF
) (
	input  wire logic                          ref_clk_i,  // System clock.
	input  wire logic                          resetn_i,   // Async reset.
	input  wire logic                          ce_i,       // Clock enable.
	input  wire logic                          link_clk_i, // Link clock.
	input  wire dsasp_pkg::dsasp_cfg_s   [1:0] cfg_i,      // Configuration.
	input  wire dsasp_pkg::dsasp_irqen_s [1:0] irq_en_i,   // Irq enables.
	input  wire logic                    [1:0] wr_i,       // Push tx word.
	input  wire logic               [1:0][31:0] wr_data_i, // Tx word.
	input  wire logic                    [1:0] rd_i,       // Pop rx word.
	output wire logic               [1:0][31:0] rd_data_o, // Rx word.
	output wire logic                    [1:0] rd_valid_o, // Rx word valid.
	input  wire logic                [1:0][3:0] err_clr_i, // Flag clears.
	output wire logic                [1:0][3:0] err_o,     // Error flags.
	output wire logic                    [1:0] dma_req_o,  // DMA requests.
	output logic                               irq_o,      // Interrupt.
	input  wire logic                    [1:0] sck_i,      // Bit clock in.
	input  wire logic                    [1:0] fs_i,       // Frame sync in.
	input  wire logic                    [1:0] sd_i,       // Serial data in.
	output wire dsasp_pkg::dsasp_pin_s   [1:0] pin_o       // Pin drives.
);
	import dsasp_pkg::*;

	localparam int unsigned AW = $clog2(FIFO_DEPTH);
	localparam int unsigned PW = AW + 1;

	function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PW-1:0] full_ref(input logic [PW-1:0] g);
		return {~g[PW-1:PW-2], g[PW-3:0]};
	endfunction

	function automatic logic [5:0] word_size(input logic [2:0] code);
		case (code)
			DSIZE_8:  return WS_8;
			DSIZE_10: return WS_10;
			DSIZE_16: return WS_16;
			DSIZE_20: return WS_20;
			DSIZE_24: return WS_24;
			DSIZE_32: return WS_32;
			default:  return WS_32;
		endcase
	endfunction

	// Locates a bit clock inside the active data of a slot.
	function automatic dsasp_bit_s bit_sel(input dsasp_cfg_s c,
			input logic [4:0] sl, input logic [5:0] sb);
		logic [5:0] ws;
		logic [5:0] wb;
		dsasp_bit_s r;
		ws = word_size(c.dsize);
		wb = sb - {1'b0, c.first_bit};
		r.act = (sl <= {1'b0, c.nslot_m1}) && c.slot_en[sl[3:0]] &&
			(sb >= {1'b0, c.first_bit}) && (wb < ws);
		r.first = (wb == 6'h00);
		r.last = (wb == ws - 6'h01);
		r.rep = c.mono && (sl == SLOT_MONO_REP);
		r.idx = c.lsb_first ? wb[4:0] : 5'(ws - 6'h01 - wb);
		return r;
	endfunction

	function automatic logic irq_term(input logic [ERR_W-1:0] e,
			input logic q, input dsasp_irqen_s en);
		return (|(e & en.err)) | (q & en.req);
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_SUB; g++) begin : g_sub
			logic [WORD_W-1:0] tx_mem [FIFO_DEPTH];
			logic [WORD_W-1:0] rx_mem [FIFO_DEPTH];
			logic [PW-1:0]     txw_bin, txw_gray, rxr_bin, rxr_gray;
			logic [PW-1:0]     txr_bin, txr_gray, rxw_bin, rxw_gray;
			logic [PW-1:0]     txr_g1, txr_g2, rxw_g1, rxw_g2;
			logic [PW-1:0]     txw_g1, txw_g2, rxr_g1, rxr_g2;
			logic              tx_full, rx_empty, tx_empty_l, rx_full_l;
			logic              push_ref, pop_ref;
			logic [WORD_W-1:0] rd_data;
			logic              rd_valid, dma_req;
			logic [ERR_W-1:0]  err, err_tgl, err_t1, err_t2, err_t3, ev;
			dsasp_cfg_s        cl;
			logic              en_l1, en_l2, ce_l1, ce_l2;
			logic              sck_s1, sck_s2, sck_s3;
			logic              fs_s1, fs_s2, sd_s1, sd_s2;
			logic [7:0]        div_cnt;
			logic              sck_r, tick_m, rise_own, fall_own;
			logic              lau_own, smp_own, lau, smp, own, follow;
			logic              lau_go, smp_go;
			logic [8:0]        bcnt, next_bcnt;
			logic [4:0]        slot, next_slot;
			logic [5:0]        sbit, next_sbit;
			logic              locked, fs_prev, fs_act, fs_start;
			logic              fs_r, sd_r, sd_oe_r, drv_oe;
			dsasp_bit_s        ba, bs;
			logic [WORD_W-1:0] tx_hold, tx_word, rx_sh, rx_word;
			logic              tx_load, rx_push;

			// System clock side of both FIFOs.
			assign tx_full = (txw_gray == full_ref(txr_g2));
			assign rx_empty = (rxr_gray == rxw_g2);
			assign push_ref = ce_i && wr_i[g] && cfg_i[g].tx && !tx_full;
			assign pop_ref = ce_i && rd_i[g] && !cfg_i[g].tx && !rx_empty;

			always_ff @(posedge ref_clk_i) begin
				if (push_ref) begin
					tx_mem[txw_bin[AW-1:0]] <= wr_data_i[g];
				end
			end

			always_ff @(posedge ref_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					txw_bin <= '0;
					txw_gray <= '0;
				end else if (push_ref) begin
					txw_bin <= txw_bin + PW'(1);
					txw_gray <= bin2gray(txw_bin + PW'(1));
				end
			end

			always_ff @(posedge ref_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					rxr_bin <= '0;
					rxr_gray <= '0;
					rd_data <= '0;
					rd_valid <= 1'b0;
				end else if (ce_i) begin
					rd_valid <= pop_ref;
					if (pop_ref) begin
						rd_data <= rx_mem[rxr_bin[AW-1:0]];
						rxr_bin <= rxr_bin + PW'(1);
						rxr_gray <= bin2gray(rxr_bin + PW'(1));
					end
				end
			end

			always_ff @(posedge ref_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					txr_g1 <= '0;
					txr_g2 <= '0;
					rxw_g1 <= '0;
					rxw_g2 <= '0;
					err_t1 <= '0;
					err_t2 <= '0;
					err_t3 <= '0;
				end else if (ce_i) begin
					txr_g1 <= txr_gray;
					txr_g2 <= txr_g1;
					rxw_g1 <= rxw_gray;
					rxw_g2 <= rxw_g1;
					err_t1 <= err_tgl;
					err_t2 <= err_t1;
					err_t3 <= err_t2;
				end
			end

			// A new event wins over a clear in the same cycle.
			always_ff @(posedge ref_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					err <= '0;
					dma_req <= 1'b0;
				end else if (ce_i) begin
					err <= (err & ~err_clr_i[g]) | (err_t2 ^ err_t3);
					dma_req <= cfg_i[g].en &&
						(cfg_i[g].tx ? !tx_full : !rx_empty);
				end
			end

			// Link clock side: enable, clock enable and pin synchronisers.
			always_ff @(posedge link_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					ce_l1 <= 1'b0;
					ce_l2 <= 1'b0;
				end else begin
					ce_l1 <= ce_i;
					ce_l2 <= ce_l1;
				end
			end

			// Configuration is only taken while the sub-block is disabled.
			always_ff @(posedge link_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					en_l1 <= 1'b0;
					en_l2 <= 1'b0;
					cl <= '0;
					sck_s1 <= 1'b0;
					sck_s2 <= 1'b0;
					sck_s3 <= 1'b0;
					fs_s1 <= 1'b0;
					fs_s2 <= 1'b0;
					sd_s1 <= 1'b0;
					sd_s2 <= 1'b0;
					txw_g1 <= '0;
					txw_g2 <= '0;
					rxr_g1 <= '0;
					rxr_g2 <= '0;
				end else if (ce_l2) begin
					en_l1 <= cfg_i[g].en;
					en_l2 <= en_l1;
					if (!en_l2) begin
						cl <= cfg_i[g];
					end
					sck_s1 <= sck_i[g];
					sck_s2 <= sck_s1;
					sck_s3 <= sck_s2;
					fs_s1 <= fs_i[g];
					fs_s2 <= fs_s1;
					sd_s1 <= sd_i[g];
					sd_s2 <= sd_s1;
					txw_g1 <= txw_gray;
					txw_g2 <= txw_g1;
					rxr_g1 <= rxr_gray;
					rxr_g2 <= rxr_g1;
				end
			end

			always_ff @(posedge link_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					div_cnt <= '0;
					sck_r <= 1'b0;
				end else if (ce_l2) begin
					if (!en_l2 || !cl.master || follow) begin
						div_cnt <= '0;
						sck_r <= 1'b0;
					end else if (tick_m) begin
						div_cnt <= '0;
						sck_r <= ~sck_r;
					end else begin
						div_cnt <= div_cnt + 8'h01;
					end
				end
			end

			assign follow = (g == 1) && cl.sync;
			assign own = cl.master || follow;
			assign tick_m = (div_cnt == cl.clk_div);
			assign rise_own = cl.master ? tick_m && !sck_r
				: sck_s2 && !sck_s3;
			assign fall_own = cl.master ? tick_m && sck_r
				: !sck_s2 && sck_s3;
			assign smp_own = cl.smp_rise ? rise_own : fall_own;
			assign lau_own = cl.smp_rise ? fall_own : rise_own;
			assign lau = follow ? g_sub[0].lau_own : lau_own;
			assign smp = follow ? g_sub[0].smp_own : smp_own;
			assign lau_go = ce_l2 && en_l2 && lau && (locked || own);
			assign smp_go = ce_l2 && en_l2 && smp && locked;
			assign fs_act = cl.fs_pol ? fs_s2 : !fs_s2;
			assign fs_start = fs_act && !fs_prev;

			always_comb begin
				next_bcnt = (bcnt == cl.frame_m1) ? 9'h000
					: bcnt + 9'h001;
				if (follow) begin
					next_bcnt = g_sub[0].next_bcnt;
				end
				next_slot = slot;
				next_sbit = sbit;
				if (next_bcnt == {8'h00, cl.fs_early}) begin
					next_slot = 5'h00;
					next_sbit = 6'h00;
				end else if (slot != SLOT_IDLE) begin
					if (sbit == cl.slot_sz_m1) begin
						next_sbit = 6'h00;
						next_slot = slot + 5'h01;
					end else begin
						next_sbit = sbit + 6'h01;
					end
				end
			end

			// Frame counters, slave alignment and frame sync errors.
			always_ff @(posedge link_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					bcnt <= '0;
					slot <= SLOT_IDLE;
					sbit <= '0;
					locked <= 1'b0;
					fs_prev <= 1'b0;
					fs_r <= 1'b0;
					drv_oe <= 1'b0;
				end else if (ce_l2) begin
					drv_oe <= en_l2 && cl.master && !follow;
					if (!en_l2) begin
						bcnt <= cl.frame_m1;
						slot <= SLOT_IDLE;
						sbit <= '0;
						locked <= 1'b0;
						fs_prev <= 1'b0;
						fs_r <= ~cl.fs_pol;
					end else begin
						if (own) begin
							locked <= 1'b1;
						end
						if (lau_go) begin
							bcnt <= next_bcnt;
							slot <= next_slot;
							sbit <= next_sbit;
							fs_r <= (next_bcnt < {1'b0, cl.fs_len}) ?
								cl.fs_pol : ~cl.fs_pol;
						end
						if (smp && !own) begin
							fs_prev <= fs_act;
							if (fs_start) begin
								bcnt <= '0;
								slot <= cl.fs_early ? SLOT_IDLE : 5'h00;
								sbit <= '0;
								locked <= 1'b1;
							end else if (locked && bcnt == 9'h000) begin
								locked <= 1'b0;
							end
						end
					end
				end
			end

			assign ba = bit_sel(cl, next_slot, next_sbit);
			assign bs = bit_sel(cl, slot, sbit);
			assign tx_empty_l = (txr_gray == txw_g2);
			assign rx_full_l = (rxw_gray == full_ref(rxr_g2));
			assign tx_load = lau_go && cl.tx && ba.act && ba.first && !ba.rep;
			assign rx_push = smp_go && !cl.tx && bs.act && bs.last && !bs.rep;
			assign tx_word = !tx_load ? tx_hold
				: (tx_empty_l ? '0 : tx_mem[txr_bin[AW-1:0]]);

			always_comb begin
				rx_word = bs.first ? '0 : rx_sh;
				rx_word[bs.idx] = sd_s2;
			end

			// Transmit: launch one bit per active bit clock.
			always_ff @(posedge link_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					txr_bin <= '0;
					txr_gray <= '0;
					tx_hold <= '0;
					sd_r <= 1'b0;
					sd_oe_r <= 1'b0;
				end else if (ce_l2) begin
					if (!en_l2 || !cl.tx) begin
						sd_oe_r <= 1'b0;
						sd_r <= 1'b0;
					end else if (lau_go) begin
						sd_oe_r <= ba.act;
						sd_r <= !cl.mute && ba.act && tx_word[ba.idx];
						tx_hold <= tx_word;
						if (tx_load && !tx_empty_l) begin
							txr_bin <= txr_bin + PW'(1);
							txr_gray <= bin2gray(txr_bin + PW'(1));
						end
					end
				end
			end

			always_ff @(posedge link_clk_i) begin
				if (rx_push && !rx_full_l) begin
					rx_mem[rxw_bin[AW-1:0]] <= rx_word;
				end
			end

			// Receive: assemble words and push them into the FIFO.
			always_ff @(posedge link_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					rxw_bin <= '0;
					rxw_gray <= '0;
					rx_sh <= '0;
				end else if (smp_go && !cl.tx && bs.act) begin
					rx_sh <= rx_word;
					if (rx_push && !rx_full_l) begin
						rxw_bin <= rxw_bin + PW'(1);
						rxw_gray <= bin2gray(rxw_bin + PW'(1));
					end
				end
			end

			always_comb begin
				ev = '0;
				ev[ERR_OVUD] = (tx_load && tx_empty_l) ||
					(rx_push && rx_full_l);
				ev[ERR_EARLY] = ce_l2 && en_l2 && smp && !own && locked &&
					fs_start && (bcnt != 9'h000);
				ev[ERR_LATE] = ce_l2 && en_l2 && smp && !own && locked &&
					!fs_start && (bcnt == 9'h000);
				ev[ERR_NRDY] = smp_go && !cl.tx && cl.ac97 &&
					slot == 5'h00 && sbit == 6'h00 && !sd_s2;
			end

			always_ff @(posedge link_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					err_tgl <= '0;
				end else begin
					err_tgl <= err_tgl ^ ev;
				end
			end

			assign pin_o[g] = '{sck: sck_r, sck_oe: drv_oe, fs: fs_r,
				fs_oe: drv_oe, sd: sd_r, sd_oe: sd_oe_r};
			assign rd_data_o[g] = rd_data;
			assign rd_valid_o[g] = rd_valid;
			assign err_o[g] = err;
			assign dma_req_o[g] = dma_req;
		end
	endgenerate

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= irq_term(g_sub[0].err, g_sub[0].dma_req, irq_en_i[0]) |
				irq_term(g_sub[1].err, g_sub[1].dma_req,
				irq_en_i[1]);
		end
	end
endmodule
`default_nettype wire

// *** tb/dsasp_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsasp_checker
	import dsasp_pkg::*;
(
	input wire logic                          ref_clk_i,  // Clock.
	input wire logic                          resetn_i,   // Reset.
	input wire logic                          link_clk_i, // Link clock.
	input wire dsasp_pkg::dsasp_cfg_s   [1:0] cfg_i,      // Config.
	input wire dsasp_pkg::dsasp_irqen_s [1:0] irq_en_i,   // Enables.
	input wire logic                    [1:0] rd_i,       // Pops.
	input wire logic                    [1:0] rd_valid_o, // Rx valid.
	input wire logic               [1:0][3:0] err_clr_i,  // Clears.
	input wire logic               [1:0][3:0] err_o,      // Flags.
	input wire logic                    [1:0] dma_req_o,  // Requests.
	input wire logic                          irq_o,      // Interrupt.
	input wire dsasp_pkg::dsasp_pin_s   [1:0] pin_o       // Pins.
);
	int   hcnt;
	int   fcnt;
	int   pcnt;
	logic sseen;
	logic fseen;
	wire logic fs_act = pin_o[0].fs ~^ cfg_i[0].fs_pol;
	wire logic any_req = |(err_o[0] & irq_en_i[0].err)
		| |(err_o[1] & irq_en_i[1].err)
		| (dma_req_o[0] & irq_en_i[0].req) | (dma_req_o[1] & irq_en_i[1].req);

	// Link clocks since the last bit clock change, and fs width and period.
	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hcnt  <= 0;
			fcnt  <= 0;
			pcnt  <= 0;
			sseen <= 1'b0;
			fseen <= 1'b0;
		end else begin
			hcnt  <= $changed(pin_o[0].sck) ? 1 : hcnt + 1;
			fcnt  <= fs_act ? fcnt + 1 : 0;
			pcnt  <= $rose(fs_act) ? 1 : pcnt + 1;
			sseen <= cfg_i[0].en && (sseen || $changed(pin_o[0].sck));
			fseen <= cfg_i[0].en && (fseen || $rose(fs_act));
		end
	end

	rd_valid_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		rd_valid_o[1] |-> $past(rd_i[1]) && !$past(cfg_i[1].tx))
		else $error("rx valid without pop");
	rd_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		rd_valid_o[1] && !rd_i[1] |=> !rd_valid_o[1])
		else $error("rx valid too long");
	err_keep_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$fell(err_o[1][0]) |-> $past(err_clr_i[1][0]))
		else $error("flag dropped without clear");
	irq_track_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		irq_o == $past(any_req))
		else $error("irq does not follow enabled sources");
	dma_idle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		!cfg_i[0].en && !$past(cfg_i[0].en) |-> !dma_req_o[0])
		else $error("request while disabled");
	sync_quiet_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
		cfg_i[1].sync && $past(cfg_i[1].sync, 4)
		|-> !pin_o[1].sck_oe && !pin_o[1].fs_oe) else $error("sync unit drives");
	sck_rate_a: assert property (@(posedge link_clk_i)
		disable iff (!resetn_i || !cfg_i[0].en)
		$changed(pin_o[0].sck) && pin_o[0].sck_oe && sseen
		|-> hcnt == int'(cfg_i[0].clk_div) + 1) else $error("bit clock rate");
	fs_width_a: assert property (@(posedge link_clk_i)
		disable iff (!resetn_i || !cfg_i[0].en)
		$fell(fs_act) && pin_o[0].fs_oe |-> fcnt ==
		int'(cfg_i[0].fs_len) * 2 * (int'(cfg_i[0].clk_div) + 1))
		else $error("frame sync width");
	frame_len_a: assert property (@(posedge link_clk_i)
		disable iff (!resetn_i || !cfg_i[0].en)
		$rose(fs_act) && fseen |-> pcnt ==
		(int'(cfg_i[0].frame_m1) + 1) * 2 * (int'(cfg_i[0].clk_div) + 1))
		else $error("frame length");
endmodule

bind dsasp_top dsasp_checker u_chk (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
	.cfg_i(cfg_i), .irq_en_i(irq_en_i), .rd_i(rd_i), .rd_valid_o(rd_valid_o),
	.err_clr_i(err_clr_i), .err_o(err_o), .dma_req_o(dma_req_o),
	.irq_o(irq_o), .pin_o(pin_o)
);
`default_nettype wire

// *** tb/dsasp_codec_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsasp_codec_model
	import dsasp_pkg::*;
#(
	parameter int WS = 8
) (
	input  wire logic                  link_clk_i, // Pattern clock.
	input  wire dsasp_pkg::dsasp_pin_s pin_i,      // Device pins.
	output logic                       sd_o        // Data to device.
);
	logic [31:0] shreg = '0;
	logic        fs_q = 1'b0;
	logic        tog = 1'b0;
	int          nbit = 0;
	logic [31:0] words[$];

	always @(posedge link_clk_i) begin
		tog <= ~tog;
	end
	// Capture on the rising bit clock, opposite to the device launch edge.
	always @(posedge pin_i.sck) begin
		if (pin_i.fs && !fs_q)
			nbit = 0;
		fs_q = pin_i.fs;
		if (pin_i.sd_oe) begin
			shreg = {shreg[30:0], pin_i.sd};
			nbit++;
			if (nbit == WS) begin
				words.push_back(32'(shreg[WS-1:0]));
				nbit = 0;
			end
		end else begin
			// A released data line means no word is in flight.
			nbit = 0;
		end
	end
	// Echo the data inverted; an undriven line wanders every link clock.
	assign sd_o = pin_i.sd_oe ? ~pin_i.sd : tog;
endmodule
`default_nettype wire

// *** tb/dsasp_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsasp_top_tb;
	import dsasp_pkg::*;
	logic                    ref_clk_i;
	logic                    link_clk_i;
	logic                    resetn_i;
	logic                    ce_i;
	dsasp_cfg_s        [1:0] cfg_i;
	dsasp_irqen_s      [1:0] irq_en_i;
	logic              [1:0] wr_i;
	logic        [1:0][31:0] wr_data_i;
	logic              [1:0] rd_i;
	logic        [1:0][31:0] rd_data_o;
	logic              [1:0] rd_valid_o;
	logic         [1:0][3:0] err_clr_i;
	logic         [1:0][3:0] err_o;
	logic              [1:0] dma_req_o;
	logic                    irq_o;
	logic              [1:0] sck_i;
	logic              [1:0] fs_i;
	logic              [1:0] sd_i;
	dsasp_pin_s        [1:0] pin_o;
	logic                    codec_sd;
	int                      err_total;
	int                      check_count;

	assign sck_i = {2{pin_o[0].sck}};
	assign fs_i = {2{pin_o[0].fs}};
	assign sd_i = {2{codec_sd}};

	dsasp_top u_dut (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
		.link_clk_i(link_clk_i), .cfg_i(cfg_i), .irq_en_i(irq_en_i),
		.wr_i(wr_i), .wr_data_i(wr_data_i), .rd_i(rd_i),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.err_clr_i(err_clr_i), .err_o(err_o), .dma_req_o(dma_req_o),
		.irq_o(irq_o), .sck_i(sck_i), .fs_i(fs_i), .sd_i(sd_i), .pin_o(pin_o)
	);
	dsasp_codec_model u_codec (
		.link_clk_i(link_clk_i), .pin_i(pin_o[0]), .sd_o(codec_sd)
	);

	always #25 ref_clk_i = ~ref_clk_i;
	always #40 link_clk_i = ~link_clk_i;

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#2;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic pop(input logic [31:0] exp);
		rd_i[1] = 1'b1;
		step(1);
		rd_i[1] = 1'b0;
		chk(rd_valid_o[1], 1'b1);
		chk(rd_data_o[1], exp);
		step(1);
	endtask

	function automatic logic [7:0] pat(input int i);
		return 8'(i * 37 + 5);
	endfunction

	// Two 8-bit slots in a 16-bit frame, fs high for the first half.
	function automatic dsasp_cfg_s mk(input logic tx);
		dsasp_cfg_s c;
		c = '0;
		c.tx = tx;
		c.master = tx;
		c.sync = !tx;
		c.dsize = DSIZE_8;
		c.slot_sz_m1 = 6'h07;
		c.nslot_m1 = 4'h1;
		c.slot_en = 16'h0003;
		c.frame_m1 = 9'h00f;
		c.fs_len = 8'h08;
		c.fs_pol = 1'b1;
		c.smp_rise = 1'b1;
		c.clk_div = 8'h03;
		return c;
	endfunction

	initial begin
		ref_clk_i = 1'b0;
		link_clk_i = 1'b0;
		resetn_i = 1'b0;
		ce_i = 1'b1;
		cfg_i = '0;
		irq_en_i = '0;
		wr_i = '0;
		wr_data_i = '0;
		rd_i = '0;
		err_clr_i = '0;
		err_total = 0;
		check_count = 0;
		step(12);
		resetn_i = 1'b1;
		step(4);
		chk(err_o, 8'h00);
		chk({dma_req_o, irq_o}, 3'h0);
		cfg_i[0] = mk(1'b1);
		cfg_i[1] = mk(1'b0);
		step(4);
		// Nine pushes into an idle transmitter: the last one must be refused.
		wr_i[0] = 1'b1;
		for (int i = 0; i < 9; i++) begin
			wr_data_i[0] = {24'hffffff, pat(i)};
			step(1);
		end
		wr_i[0] = 1'b0;
		cfg_i[0].en = 1'b1;
		cfg_i[1].en = 1'b1;
		for (int i = 0; i < 4000; i++) begin
			if (err_o[0][0] === 1'b1 && err_o[1][0] === 1'b1)
				break;
			step(1);
		end
		chk({err_o[1][0], err_o[0][0]}, 2'h3);
		chk(irq_o, 1'b0);
		chk(dma_req_o, 2'h3);
		chk({rd_valid_o[0], err_o[1][3:1], err_o[0][3:1]}, 7'h00);
		irq_en_i[1].err = 4'h1;
		step(2);
		chk(irq_o, 1'b1);
		for (int i = 0; i < 8; i++)
			pop({24'h0, ~pat(i)});
		chk(u_codec.words.size() >= 9, 1'b1);
		for (int i = 0; i < 9; i++)
			chk(u_codec.words[i], i < 8 ? {24'h0, pat(i)} : 32'h0);
		cfg_i[0].en = 1'b0;
		cfg_i[1].en = 1'b0;
		step(20);
		chk({irq_o, err_o[1][0]}, 2'h3);
		err_clr_i[1][0] = 1'b1;
		step(1);
		err_clr_i[1][0] = 1'b0;
		step(2);
		chk({irq_o, err_o[1][0]}, 2'h0);
		// A muted transmitter still takes the word but sends silence.
		u_codec.words.delete();
		cfg_i[0].mute = 1'b1;
		wr_i[0] = 1'b1;
		wr_data_i[0] = 32'h000000a5;
		step(1);
		wr_i[0] = 1'b0;
		cfg_i[0].en = 1'b1;
		for (int i = 0; i < 400 && u_codec.words.size() == 0; i++)
			step(1);
		chk(u_codec.words.size() > 0, 1'b1);
		chk(u_codec.words[0], 32'h0);
		// Least significant bit first: the codec shifts MSB first, so it
		// sees the byte mirrored.
		cfg_i[0].en = 1'b0;
		step(20);
		u_codec.words.delete();
		cfg_i[0].mute = 1'b0;
		cfg_i[0].lsb_first = 1'b1;
		wr_i[0] = 1'b1;
		wr_data_i[0] = 32'h00000035;
		step(1);
		wr_i[0] = 1'b0;
		cfg_i[0].en = 1'b1;
		for (int i = 0; i < 400 && u_codec.words.size() == 0; i++)
			step(1);
		chk(u_codec.words.size() > 0, 1'b1);
		chk(u_codec.words[0], 32'h000000ac);
		results();
	end

	// The whole run takes about 63 us; give up well after that.
	initial begin
		#400000;
		err_total++;
		results();
	end
endmodule
`default_nettype wire
